//--- src/cicr_pkg.sv
// Package for the core interrupt control register block.
// Assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock.
package cicr_pkg;
  // Register indices of the two mirrors of the control register
  localparam logic [7:0] CICR_ADDR_LOW      = 8'h0b;
  localparam logic [7:0] CICR_ADDR_HIGH     = 8'h8b;
  // Register indices are not word aligned; the byte address is four times the index
  localparam logic [9:0] CICR_BYTE_LOW      = 10'h02c;
  localparam logic [9:0] CICR_BYTE_HIGH     = 10'h22c;
  // Own status register: peripheral flags and request level
  localparam logic [9:0] CICR_BYTE_STATUS   = 10'h300;
  // Field positions
  localparam int CICR_GLB_EN   = 7;
  localparam int CICR_GRP_EN   = 6;
  localparam int CICR_TIM_EN   = 5;
  localparam int CICR_EXT_EN   = 4;
  localparam int CICR_PRT_EN   = 3;
  localparam int CICR_TIM_FLAG = 2;
  localparam int CICR_EXT_FLAG = 1;
  localparam int CICR_PRT_FLAG = 0;
  // Reset value; the port change flag is undefined and taken as zero
  localparam logic [7:0] CICR_RESET         = 8'h00;
  localparam logic [1:0] CICR_RESP_OKAY     = 2'h0;
  localparam logic [1:0] CICR_RESP_SLVERR   = 2'h2;
endpackage : cicr_pkg

//--- src/cicr_sync.sv
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are levels that stay stable for several clocks.
`timescale 1ns/100ps
module cicr_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Pin side and synchronised side
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] pins_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1    <= '0;
      pins_sync <= '0;
    end
    else
    begin
      stage1    <= pins;
      pins_sync <= stage1;
    end
  end
endmodule : cicr_sync

//--- src/cicr_top.sv
// Core interrupt control register with its AXI4-Lite slave.
// Assumes timer0 overflow arrives as a one-cycle pulse on aclk and
// the external and upper port pins are asynchronous levels.
//
// What this block does
// - The control register answers at both mirrored addresses, one shared storage.
// - Each flag sets on its condition whatever the enable bits hold.
// - Global enable bit 7 permits unmasked requests and when zero blocks them all.
// - Peripheral group enable bit 6 passes or blocks all peripheral requests.
// - No peripheral source raises a request unless bit 6 is set.
// - Timer0 enable bit 5 decides whether the timer0 flag joins the request.
// - Timer0 flag bit 2 sets on overflow and holds until software writes zero.
// - External pin flag bit 1 sets on the pin event and holds; bit 4 enables it.
// - Port change enable bit 3 masks or passes the port change flag.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
module cicr_top
  import cicr_pkg::*;
#(
  parameter int PERIPH_WIDTH = 4
) (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address and data
  input  wire logic [9:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [9:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Interrupt sources
  input  wire logic                    timer0_overflow,
  input  wire logic                    external_interrupt_pin,
  input  wire logic                    ext_edge_rising,
  input  wire logic [3:0]              upper_port_pins,
  input  wire logic [PERIPH_WIDTH-1:0] periph_request,
  // Request to the core
  output logic                         irq_request
);
  logic [7:0]  interrupt_control;
  logic [4:0]  pins_sync;
  logic [4:0]  pins_prev;
  logic        aw_held;
  logic        w_held;
  logic [9:0]  aw_addr;
  logic [7:0]  w_data;
  logic        w_lane0;
  logic        do_write;
  logic        ctrl_hit;
  logic        ext_event;
  logic        port_event;
  logic        periph_any;
  logic        next_irq;
  logic [31:0] next_rdata;

  function automatic logic is_ctrl(input logic [9:0] addr);
    is_ctrl = (addr[9:2] == CICR_BYTE_LOW[9:2]) || (addr[9:2] == CICR_BYTE_HIGH[9:2]);
  endfunction : is_ctrl

  // Status word is read-only; a write there is accepted and ignored
  function automatic logic is_status(input logic [9:0] addr);
    is_status = (addr[9:2] == CICR_BYTE_STATUS[9:2]);
  endfunction : is_status

  cicr_sync #(.WIDTH(5)) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pins      ({external_interrupt_pin, upper_port_pins}),
    .pins_sync (pins_sync)
  );

  // One cycle of history per pin turns synchronised levels into edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pins_prev <= '0;
    else
      pins_prev <= pins_sync;
  end

  // Edge selected by the edge input; history resets to zero, so a pin high after reset reads as a rising edge
  assign ext_event  = ext_edge_rising ? (pins_sync[4] & ~pins_prev[4])
                                      : (~pins_sync[4] & pins_prev[4]);
  assign port_event = |(pins_sync[3:0] ^ pins_prev[3:0]);

  // Write channel: address and data taken in either order
  // A pending response stalls the next write so bvalid is never overwritten
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign ctrl_hit = is_ctrl(aw_addr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CICR_RESP_OKAY;
    end
    else
    begin
      // Readies are one-cycle pulses; a new beat waits until the held pair is written
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (ctrl_hit || is_status(aw_addr))
                        ? CICR_RESP_OKAY : CICR_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control register: events set flags and win over a software clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      interrupt_control <= CICR_RESET;
    else
    begin
      if (do_write && ctrl_hit && w_lane0)
        interrupt_control <= w_data;
      if (timer0_overflow)
        interrupt_control[CICR_TIM_FLAG] <= 1'b1;
      if (ext_event)
        interrupt_control[CICR_EXT_FLAG] <= 1'b1;
      if (port_event)
        interrupt_control[CICR_PRT_FLAG] <= 1'b1;
    end
  end

  // Peripheral flags live in their own registers elsewhere; only gated here,
  // so a cleared group enable blocks them even with a flag pending
  assign periph_any = (|periph_request) && interrupt_control[CICR_GRP_EN];

  always_comb
  begin
    next_irq = interrupt_control[CICR_GLB_EN] && (
      (interrupt_control[CICR_TIM_EN] && interrupt_control[CICR_TIM_FLAG]) ||
      (interrupt_control[CICR_EXT_EN] && interrupt_control[CICR_EXT_FLAG]) ||
      (interrupt_control[CICR_PRT_EN] && interrupt_control[CICR_PRT_FLAG]) ||
      periph_any);
  end

  // Registered so the request is a clean flip-flop output; costs one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_request <= 1'b0;
    else
      irq_request <= next_irq;
  end

  // Read channel
  always_comb
  begin
    next_rdata = '0;
    if (is_ctrl(s_axi_araddr))
      next_rdata[7:0] = interrupt_control;
    else if (is_status(s_axi_araddr))
      next_rdata = {{(31 - PERIPH_WIDTH){1'b0}}, irq_request, periph_request};
  end

  // Read data are captured at the address handshake and held until rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= CICR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= (is_ctrl(s_axi_araddr) || is_status(s_axi_araddr))
                        ? CICR_RESP_OKAY : CICR_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : cicr_top

//--- verif/cicr_properties.sv
// Port assertions for the control register block.
// Bound into cicr_top; assumes the bench offers aw and w together.
`timescale 1ns/100ps
module cicr_properties
  import cicr_pkg::*;
#(
  parameter int PERIPH_WIDTH = 4
) (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Register bus
  input wire logic [9:0]              s_axi_awaddr,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic [31:0]             s_axi_wdata,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  // Sources and request
  input wire logic                    timer0_overflow,
  input wire logic [PERIPH_WIDTH-1:0] periph_request,
  input wire logic                    irq_request
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] last_wr;
  logic       wr_hit;
  // Shadow of the last control write, so request checks know the enables
  assign wr_hit = s_axi_awvalid && s_axi_awready &&
                  (s_axi_awaddr == CICR_BYTE_LOW || s_axi_awaddr == CICR_BYTE_HIGH);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      last_wr <= 8'h00;
    else if (wr_hit)
      last_wr <= s_axi_wdata[7:0];
  end
  a_write_latency: assert property (s_axi_awready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_latency: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_global_off: assert property (wr_hit && !s_axi_wdata[7] |-> ##3 !irq_request)
    else $error("request kept with global enable clear");
  a_group_off: assert property (wr_hit && s_axi_wdata[6:3] == 4'h0 |-> ##3 !irq_request)
    else $error("peripheral request passed group gate");
  a_group_on: assert property (wr_hit && s_axi_wdata[7:6] == 2'h3 ##1
    (|periph_request) [*3] |-> irq_request) else $error("peripheral request lost");
  a_timer_hold: assert property (timer0_overflow && last_wr[7] && last_wr[5]
    |-> ##2 irq_request [*4]) else $error("timer request missing");
  a_timer_mask: assert property (timer0_overflow && last_wr == 8'h80 |=> !irq_request [*3])
    else $error("masked timer raised request");
  cover property (wr_hit);
  cover property ($rose(irq_request));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule : cicr_properties

bind cicr_top cicr_properties #(.PERIPH_WIDTH(PERIPH_WIDTH)) i_props (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .timer0_overflow, .periph_request, .irq_request);

//--- verif/core_interrupt_control_register_tb.sv
// Self-checking bench for the control register block.
// Drives the AXI4-Lite port and the sources directly, one clock.
`timescale 1ns/100ps
module core_interrupt_control_register_tb
  import cicr_pkg::*;
;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, timer0_overflow = 1'h0;
  logic        external_interrupt_pin = 1'h0, ext_edge_rising = 1'h1;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 4'hf, upper_port_pins = 4'h0, periph_request = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq_request;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          n_errors = 0, comparisons = 0, cycles = 0;
  // Control value in bits 11:4, expected request in bit 0
  logic [11:0] tbl [10] = '{12'h240, 12'ha41, 12'h840, 12'h891, 12'h810,
                            12'h921, 12'h820, 12'h800, 12'hc01, 12'h400};
  cicr_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer0_overflow, .external_interrupt_pin,
    .ext_edge_rising, .upper_port_pins, .periph_request, .irq_request);
  always #50 aclk = ~aclk;
  task automatic final_report();
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_data, {24'h000000, e});
  endtask : rchk
  task automatic tick();
    timer0_overflow <= 1'h1;
    @(posedge aclk);
    timer0_overflow <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask : tick
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rchk(CICR_BYTE_LOW, 8'h00);
    wr(CICR_BYTE_HIGH, 8'h78);
    rchk(CICR_BYTE_LOW, 8'h78);
    wr(CICR_BYTE_LOW, 8'h00);
    rchk(CICR_BYTE_HIGH, 8'h00);
    tick();
    rchk(CICR_BYTE_LOW, 8'h04);
    repeat (20) @(posedge aclk);
    rchk(CICR_BYTE_LOW, 8'h04);
    chk({31'h0, irq_request}, 32'h0);
    wr(CICR_BYTE_LOW, 8'h00);
    external_interrupt_pin <= 1'h1;
    repeat (8) @(posedge aclk);
    rchk(CICR_BYTE_LOW, 8'h02);
    wr(CICR_BYTE_LOW, 8'h00);
    upper_port_pins <= 4'h8;
    repeat (8) @(posedge aclk);
    rchk(CICR_BYTE_LOW, 8'h01);
    wr(CICR_BYTE_LOW, 8'h80);
    tick();
    rchk(CICR_BYTE_LOW, 8'h84);
    wr(CICR_BYTE_LOW, 8'ha0);
    tick();
    chk({31'h0, irq_request}, 32'h1);
    periph_request <= 4'h1;
    foreach (tbl[i])
    begin
      wr(CICR_BYTE_LOW, tbl[i][11:4]);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq_request}, {31'h0, tbl[i][0]});
    end
    rchk(CICR_BYTE_STATUS, 8'h01);
    rd(10'h100);
    chk(rd_data, 32'h0);
    chk({30'h0, resp}, {30'h0, CICR_RESP_SLVERR});
    wr(10'h100, 8'hff);
    chk({30'h0, resp}, {30'h0, CICR_RESP_SLVERR});
    rchk(CICR_BYTE_HIGH, 8'h40);
    ext_edge_rising <= 1'h0;
    external_interrupt_pin <= 1'h0;
    repeat (8) @(posedge aclk);
    rchk(CICR_BYTE_LOW, 8'h42);
    s_axi_wstrb <= 4'he;
    wr(CICR_BYTE_LOW, 8'ha0);
    s_axi_wstrb <= 4'hf;
    rchk(CICR_BYTE_HIGH, 8'h42);
    final_report();
  end
endmodule : core_interrupt_control_register_tb
